/* File: src/lms_pkg.sv */
// lms_pkg: offsets, fields, reset values and timing for the scroll/update block
// assumes a 125 MHz sys_clk; register indices are word indices on AXI4-Lite
package lms_pkg;
	localparam int unsigned CLK_NS    = 8;
	// base scroll unit, also the step time for a zero code
	localparam int unsigned BASE_NS   = 100_000_000;
	localparam int unsigned BASE_CYC  = (BASE_NS + CLK_NS - 1) / CLK_NS;
	// blink slot: one sixteenth of a 1 s cycle
	localparam int unsigned SLOT_NS   = 62_500_000;
	localparam int unsigned SLOT_CYC  = SLOT_NS / CLK_NS;
	// one full matrix scan
	localparam int unsigned SCAN_NS   = 9_775_000;
	localparam int unsigned SCAN_CYC  = SCAN_NS / CLK_NS;
	// external clock edges per base unit (64 ns link period)
	localparam int unsigned EXT_BASE  = 1_562_500;
	localparam int unsigned NDOT      = 119;
	localparam logic [4:0]  HROWS     = 5'd17;
	localparam logic [4:0]  VLINES    = 5'd7;
	// register indices, byte address is four times the index
	localparam logic [6:0]  IDX_PAGE  = 7'h01;
	localparam logic [6:0]  IDX_STAT  = 7'h05;
	localparam logic [6:0]  IDX_EXTC  = 7'h06;
	localparam logic [6:0]  IDX_MTX   = 7'h07;
	localparam logic [6:0]  IDX_CTRL  = 7'h0a;
	localparam logic [6:0]  IDX_CFG   = 7'h0b;
	localparam logic [6:0]  IDX_IEN   = 7'h0c;
	localparam logic [6:0]  IDX_ICLR  = 7'h0d;
	localparam logic [6:0]  IDX_IST   = 7'h0e;
	localparam logic [6:0]  IDX_DOT0  = 7'h03;
	localparam logic [6:0]  IDX_DOTN  = 7'h79;
	// cfg fields: [2:0] step code, [4:3] direction
	localparam int unsigned CFG_DIR   = 3;
	localparam logic [7:0]  CFG_RST   = 8'h00;
	localparam logic [1:0]  DIR_L2R   = 2'd0;
	localparam int unsigned STAT_FRM  = 1;
	localparam logic [1:0]  RESP_OK   = 2'b00;
	localparam logic [1:0]  RESP_ERR  = 2'b10;
endpackage

/* File: src/lms_scroll.sv */
// lms_scroll: scroll step timing, frame-done event and dot data update control
// assumes an AXI4-Lite master on sys_clk and an optional external clock on ext_clk
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module lms_scroll #(
	parameter int unsigned BASE_CYCLES = lms_pkg::BASE_CYC,
	parameter int unsigned SLOT_CYCLES = lms_pkg::SLOT_CYC,
	parameter int unsigned SCAN_CYCLES = lms_pkg::SCAN_CYC,
	parameter int unsigned EXT_EDGES   = lms_pkg::EXT_BASE
) (
	input  wire logic                      sys_clk,
	input  wire logic                      rst,
	input  wire logic                      ext_clk,
	input  wire logic [31:0]               s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [31:0]               s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic                           frame_done_event,
	output logic                           irq,
	output logic [4:0]                     scroll_row,
	output logic [lms_pkg::NDOT-1:0]       dot_on
);
	import lms_pkg::*;

	typedef struct packed {
		logic                 page;
		logic                 ext_sel;
		logic                 matrix_display_on;
		logic                 scroll_run;
		logic                 run_prev;
		logic [7:0]           cfg;
		logic [NDOT-1:0][7:0] pend;
		logic [NDOT-1:0][7:0] live;
		logic [NDOT-1:0][3:0] pos;
		logic [NDOT-1:0][3:0] hold;
		logic [NDOT-1:0]      on;
		logic                 frame_pend;
		logic                 ist;
		logic                 ien;
		logic                 irq;
		logic [23:0]          base_cnt;
		logic [2:0]           unit_cnt;
		logic [23:0]          slot_cnt;
		logic [2:0]           slot_div;
		logic [23:0]          scan_cnt;
		logic [4:0]           row;
		logic                 ext_s1;
		logic                 ext_s2;
		logic                 ext_p;
		logic                 aw_h;
		logic [6:0]           aw_a;
		logic                 w_h;
		logic [7:0]           wd;
		logic                 ws;
		logic                 awr;
		logic                 wr;
		logic                 bv;
		logic [1:0]           br;
		logic                 arr;
		logic                 rv;
		logic [7:0]           rd;
		logic [1:0]           rr;
	} lms_state_t;

	lms_state_t s_q;
	lms_state_t s_d;
	logic       step;
	logic       scan_end;
	logic       rd_stat;
	logic       frame_hit;
	logic [4:0] frame_len;

	always_comb begin
		logic       do_wr;
		logic       base_hit;
		logic       slot_hit;
		logic [3:0] tk;
		logic [6:0] ra;
		logic       ok;
		logic [1:0] dn;
		logic [1:0] dl;
		logic [1:0] dd;
		do_wr     = 1'b0;
		base_hit  = 1'b0;
		slot_hit  = 1'b0;
		tk        = 4'h0;
		ra        = 7'h00;
		ok        = 1'b0;
		dn        = 2'd0;
		dl        = 2'd0;
		dd        = 2'd0;
		s_d       = s_q;
		step      = 1'b0;
		scan_end  = 1'b0;
		rd_stat   = 1'b0;
		frame_hit = 1'b0;

		// external clock: two synchroniser stages, edges found by comparing the second stage with a third delayed copy
		s_d.ext_s1 = ext_clk;
		s_d.ext_s2 = s_q.ext_s1;
		s_d.ext_p  = s_q.ext_s2;

		// write channel: address and data taken in either order
		if (s_axi_awvalid && s_q.awr) begin
			s_d.aw_h = 1'b1;
			s_d.aw_a = s_axi_awaddr[8:2];
		end
		if (s_axi_wvalid && s_q.wr) begin
			s_d.w_h = 1'b1;
			s_d.wd  = s_axi_wdata[7:0];
			s_d.ws  = s_axi_wstrb[0];
		end
		if (s_q.aw_h && s_q.w_h && !s_q.bv) begin
			do_wr  = s_q.ws;
			s_d.aw_h = 1'b0;
			s_d.w_h  = 1'b0;
			s_d.bv   = 1'b1;
			s_d.br   = RESP_ERR;
			if (s_q.aw_a == IDX_PAGE) begin
				s_d.br = RESP_OK;
				if (do_wr) s_d.page = s_q.wd[0];
			end else if (s_q.page) begin
				if (s_q.aw_a >= IDX_DOT0 && s_q.aw_a <= IDX_DOTN) begin
					s_d.br = RESP_OK;
					if (do_wr) s_d.pend[s_q.aw_a - IDX_DOT0] = s_q.wd;
				end
			end else begin
				s_d.br = RESP_OK;
				unique case (s_q.aw_a)
					IDX_EXTC: if (do_wr) s_d.ext_sel = s_q.wd[0];
					IDX_MTX:  if (do_wr) s_d.matrix_display_on = s_q.wd[0];
					IDX_CTRL: if (do_wr) s_d.scroll_run = s_q.wd[0];
					IDX_CFG:  if (do_wr) s_d.cfg = s_q.wd;
					IDX_IEN:  if (do_wr) s_d.ien = s_q.wd[0];
					IDX_ICLR: if (do_wr && s_q.wd[0]) s_d.ist = 1'b0;
					IDX_STAT, IDX_IST: ;
					default:  s_d.br = RESP_ERR;
				endcase
			end
		end
		if (s_q.bv && s_axi_bready) s_d.bv = 1'b0;
		s_d.awr = !s_d.aw_h && !s_d.bv;
		s_d.wr  = !s_d.w_h && !s_d.bv;

		// read channel: answer one cycle after the address is taken
		if (s_axi_arvalid && s_q.arr) begin
			ra   = s_axi_araddr[8:2];
			s_d.rv = 1'b1;
			s_d.rd = 8'h00;
			ok     = 1'b1;
			if (ra == IDX_PAGE) s_d.rd = {7'h00, s_q.page};
			else if (s_q.page) begin
				ok = (ra >= IDX_DOT0 && ra <= IDX_DOTN);
				if (ok) s_d.rd = s_q.pend[ra - IDX_DOT0];
			end else begin
				unique case (ra)
					IDX_STAT: begin
						s_d.rd  = {6'h00, s_q.frame_pend, s_q.scroll_run};
						rd_stat = 1'b1;
					end
					IDX_EXTC: s_d.rd = {7'h00, s_q.ext_sel};
					IDX_MTX:  s_d.rd = {7'h00, s_q.matrix_display_on};
					IDX_CTRL: s_d.rd = {7'h00, s_q.scroll_run};
					IDX_CFG:  s_d.rd = s_q.cfg;
					IDX_IEN:  s_d.rd = {7'h00, s_q.ien};
					IDX_IST:  s_d.rd = {7'h00, s_q.ist};
					IDX_ICLR: s_d.rd = 8'h00;
					default:  ok = 1'b0;
				endcase
			end
			s_d.rr = ok ? RESP_OK : RESP_ERR;
		end else if (s_q.rv && s_axi_rready) begin
			s_d.rv = 1'b0;
		end
		s_d.arr = !s_d.rv;

		// base unit: sys_clk count, or sampled external rising edges
		if (!s_q.ext_sel) begin
			base_hit = (s_q.base_cnt == 24'(BASE_CYCLES - 1));
			s_d.base_cnt = base_hit ? 24'h000000 : s_q.base_cnt + 24'h000001;
		end else if (s_q.ext_s2 && !s_q.ext_p) begin
			base_hit = (s_q.base_cnt == 24'(EXT_EDGES - 1));
			s_d.base_cnt = base_hit ? 24'h000000 : s_q.base_cnt + 24'h000001;
		end
		// code n steps every n+1 units, zero gives 0.1 s
		if (base_hit) begin
			step = (s_q.unit_cnt == s_q.cfg[2:0]);
			s_d.unit_cnt = step ? 3'd0 : s_q.unit_cnt + 3'd1;
		end

		// one row per step while running
		s_d.run_prev = s_q.scroll_run;
		frame_len = s_q.cfg[CFG_DIR+1] ? VLINES : HROWS;
		if (s_q.scroll_run && s_q.run_prev && step) begin
			// wrap after a full frame; a row left from another direction wraps too
			frame_hit = (s_q.row >= frame_len - 5'd1);
			s_d.row   = frame_hit ? 5'd0 : s_q.row + 5'd1;
		end
		if (s_q.scroll_run && !s_q.run_prev) begin
			s_d.base_cnt = 24'h000000;
			s_d.unit_cnt = 3'd0;
			s_d.row      = 5'd0;
		end

		// read clears, set wins and holds
		if (rd_stat) s_d.frame_pend = 1'b0;
		if (frame_hit) begin
			s_d.frame_pend = 1'b1;
			s_d.ist        = 1'b1;
		end
		s_d.irq = s_d.ist && s_d.ien;

		// blink slot ticks for 1/2/3 s cycles
		slot_hit = (s_q.slot_cnt == 24'(SLOT_CYCLES - 1));
		s_d.slot_cnt = slot_hit ? 24'h000000 : s_q.slot_cnt + 24'h000001;
		if (slot_hit) s_d.slot_div = (s_q.slot_div == 3'd5) ? 3'd0 : s_q.slot_div + 3'd1;
		// tk[n] ticks on every nth slot; code 0 is always on and never advances
		tk = {slot_hit && (s_q.slot_div == 3'd0 || s_q.slot_div == 3'd3),
		      slot_hit && !s_q.slot_div[0],
		      slot_hit,
		      1'b0};
		scan_end = (s_q.scan_cnt == 24'(SCAN_CYCLES - 1));
		s_d.scan_cnt = scan_end ? 24'h000000 : s_q.scan_cnt + 24'h000001;

		for (int i = 0; i < NDOT; i++) begin
			dn = s_q.pend[i][1:0];
			dl = s_q.live[i][1:0];
			dd = (dn > dl) ? dn - dl : dl - dn;
			// cycle 1/2/3 advance on every 1st/2nd/3rd slot
			if (tk[s_q.live[i][3:2]] && s_q.live[i][3:2] != 2'd0) begin
				if (s_q.hold[i] != 4'h0) s_d.hold[i] = s_q.hold[i] - 4'h1;
				else s_d.pos[i] = s_q.pos[i] + 4'h1;
			end
			if (scan_end) begin
				s_d.live[i] = s_q.pend[i];
				// delay change while scrolling is stopped restarts this dot only
				if (!s_q.scroll_run && dn != dl) begin
					s_d.pos[i]  = 4'h0;
					s_d.hold[i] = {dd, 2'b00};
				end
				// cycle change keeps pos and hold
			end
			if (s_q.scroll_run || s_q.live[i][3:2] == 2'd0)
				s_d.on[i] = s_q.matrix_display_on && s_q.live[i][7:4] != 4'h0;
			else
				s_d.on[i] = s_q.matrix_display_on && s_q.live[i][7:4] != 4'h0
				            && s_q.hold[i] == 4'h0 && !s_q.pos[i][3];
		end

		if (rst) begin
			s_d     = '0;
			s_d.cfg = CFG_RST;
		end
	end

	always_ff @(posedge sys_clk) begin
		s_q <= s_d;
	end

	assign s_axi_awready    = s_q.awr;
	assign s_axi_wready     = s_q.wr;
	assign s_axi_bvalid     = s_q.bv;
	assign s_axi_bresp      = s_q.br;
	assign s_axi_arready    = s_q.arr;
	assign s_axi_rvalid     = s_q.rv;
	assign s_axi_rresp      = s_q.rr;
	assign s_axi_rdata      = {24'h000000, s_q.rd};
	assign frame_done_event = s_q.frame_pend;
	assign irq              = s_q.irq;
	assign scroll_row       = s_q.row;
	assign dot_on           = s_q.on;

	cfg_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		s_q.aw_h && s_q.w_h && !s_q.bv && s_q.ws && !s_q.page && s_q.aw_a == IDX_CFG
		|=> s_q.cfg == $past(s_q.wd)) else $error("cfg write lost");
	step_reset_a: assert property (@(posedge sys_clk)
		rst |=> s_q.cfg[2:0] == 3'd0 && !s_q.frame_pend) else $error("reset step code");
	hrow_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
		s_q.scroll_run && s_q.run_prev && step && !s_q.cfg[CFG_DIR+1] && s_q.row == 5'd16
		|=> s_q.row == 5'd0 && s_q.frame_pend) else $error("row 17 wrap missed");
	vline_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
		s_q.scroll_run && s_q.run_prev && step && s_q.cfg[CFG_DIR+1] && s_q.row == 5'd6
		|=> s_q.row == 5'd0 && s_q.frame_pend) else $error("line 7 wrap missed");
	frame_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		s_q.frame_pend && !rd_stat |=> s_q.frame_pend) else $error("frame flag dropped");
	// read clears unless set again, returning the flag as it stood
	read_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
		rd_stat && !frame_hit |=> !s_q.frame_pend && s_q.rd[STAT_FRM] == $past(s_q.frame_pend))
		else $error("read did not clear");
	run_start_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(s_q.scroll_run) |=> s_q.row == 5'd0 && s_q.unit_cnt == 3'd0)
		else $error("scroll start not fresh");
	// live data only changes at scan end
	scan_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
		!scan_end |=> s_q.live[0] == $past(s_q.live[0])) else $error("live changed mid scan");
	delay_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
		scan_end && !s_q.scroll_run && s_q.pend[1][1:0] != s_q.live[1][1:0]
		|=> s_q.pos[1] == 4'h0 && s_q.hold[1] != 4'h0) else $error("delay rewrite no restart");
	cycle_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
		scan_end && s_q.pend[1][1:0] == s_q.live[1][1:0] && s_q.hold[1] == 4'h0
		&& s_q.slot_cnt != 24'(SLOT_CYCLES - 1) |=> s_q.pos[1] == $past(s_q.pos[1]))
		else $error("cycle reset dot");

endmodule // lms_scroll

/* File: verif/lms_host.sv */
// lms_host: host processor model, an AXI4-Lite master worked by bench tasks
// assumes the slave answers in its own time; the bench watchdog ends a hang
`timescale 1ns/1ps
module lms_host (
	input  wire logic        sys_clk,
	input  wire logic        irq,
	output logic [31:0]      awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [31:0]      araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	import lms_pkg::*;
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// address and data go out together, each dropped once taken
	task automatic wr(input logic [6:0] idx, input logic [7:0] v, output logic [1:0] r);
		@(posedge sys_clk);
		awaddr <= {23'h0, idx, 2'b00};
		wdata <= {24'h0, v};
		wstrb <= 4'hf;
		{awvalid, wvalid, bready} <= 3'b111;
		forever begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] idx, output logic [31:0] v, output logic [1:0] r);
		@(posedge sys_clk);
		araddr <= {23'h0, idx, 2'b00};
		{arvalid, rready} <= 2'b11;
		forever begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// config first, then run bit; a pending flag left from the last run is cleared first
	task automatic start_scroll(input logic [7:0] cfg);
		logic [1:0]  r;
		logic [31:0] v;
		rd(IDX_STAT, v, r);
		wr(IDX_ICLR, 8'h01, r);
		wr(IDX_CFG, cfg, r);
		wr(IDX_CTRL, 8'h01, r);
	endtask
	task automatic ack_frame(output logic [31:0] v);
		logic [1:0] r;
		while (irq !== 1'b1) @(posedge sys_clk);
		rd(IDX_STAT, v, r);
	endtask
endmodule // lms_host

/* File: verif/led_matrix_scroll_update_tb.sv */
// led_matrix_scroll_update_tb: self-checking bench for lms_scroll
// assumes lms_host as bus partner; counts shortened by parameters
`timescale 1ns/1ps
module led_matrix_scroll_update_tb;
	import lms_pkg::*;
	localparam int BC = 8;
	logic            sys_clk, rst, ext_clk, irq, frame_done_event;
	logic [31:0]     awaddr, wdata, araddr, rdata, d;
	logic [3:0]      wstrb;
	logic            awvalid, awready, wvalid, wready, bvalid, bready;
	logic            arvalid, arready, rvalid, rready;
	logic [1:0]      bresp, rresp, r;
	logic [4:0]      scroll_row;
	logic [NDOT-1:0] dot_on;
	logic [2:0]      code;
	int              err_total, n_tests, seed, k, a, b;
	lms_scroll #(.BASE_CYCLES(BC), .SLOT_CYCLES(4), .SCAN_CYCLES(16), .EXT_EDGES(2))
	u_lms_scroll (.sys_clk, .rst, .ext_clk, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.frame_done_event, .irq, .scroll_row, .dot_on);
	lms_host u_lms_host (.sys_clk, .irq, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready);
	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;
	// link clock free running, phase off the system clock
	initial begin
		ext_clk = 1'b0;
		#3;
		forever #32 ext_clk = ~ext_clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, g, input int tol);
		n_tests++;
		if (!((tol == 0) ? (g === e) : (g + tol >= e && g <= e + tol))) begin
			err_total++;
			$display("MISMATCH %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic frame(input int e, input int tol);
		int n;
		n = 0;
		while (frame_done_event !== 1'b1 && n < 4000) begin
			@(posedge sys_clk);
			n++;
		end
		chk("frame_cycles", e, n, tol);
	endtask
	// frame length in cycles: 17 rows or 7 lines of (code+1) base units
	function automatic int exp_frame(input logic vert, input logic [2:0] c);
		return (vert ? 7 : 17) * (int'(c) + 1) * BC;
	endfunction
	task automatic results;
		$display("errors %0d of %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		results;
	end
	initial begin
		rst = 1'b1;
		seed = 27;
		err_total = 0;
		n_tests = 0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		u_lms_host.rd(IDX_CFG, d, r);
		chk("cfg_reset", {24'h0, CFG_RST}, d, 0);
		chk("frame_reset", 0, frame_done_event, 0);
		u_lms_host.rd(7'h20, d, r);
		chk("rd_unmapped", RESP_ERR, r, 0);
		u_lms_host.wr(7'h20, 8'hff, r);
		chk("wr_unmapped", RESP_ERR, r, 0);
		u_lms_host.wr(IDX_IEN, 8'h01, r);
		chk("wr_ok", RESP_OK, r, 0);
		u_lms_host.wr(IDX_MTX, 8'h01, r);
		for (k = 0; k < 4; k++) begin
			code = 3'($unsigned($random(seed)) % 3);
			u_lms_host.wr(IDX_CTRL, 8'h00, r);
			u_lms_host.start_scroll({3'b000, 2'(k), code});
			frame(exp_frame(k > 1, code), 6);
			chk("row_wrap", 0, scroll_row, 0);
			chk("irq_set", 1, irq, 0);
			u_lms_host.ack_frame(d);
			chk("stat", 32'h3, d, 0);
			chk("frame_clr", 0, frame_done_event, 0);
			u_lms_host.wr(IDX_ICLR, 8'h01, r);
			chk("irq_clr", 0, irq, 0);
		end
		u_lms_host.wr(IDX_CTRL, 8'h00, r);
		u_lms_host.start_scroll(8'h00);
		frame(exp_frame(1'b0, 3'd0), 6);
		a = 0;
		repeat (400) begin
			@(posedge sys_clk);
			if (frame_done_event !== 1'b1) a++;
		end
		chk("frame_hold", 0, a, 0);
		u_lms_host.ack_frame(d);
		u_lms_host.wr(IDX_CTRL, 8'h00, r);
		// two link edges per base unit, eight cycles per link period
		u_lms_host.wr(IDX_EXTC, 8'h01, r);
		u_lms_host.start_scroll(8'h10);
		frame(7 * 2 * 8, 20);
		u_lms_host.ack_frame(d);
		chk("stat_ext", 32'h3, d, 0);
		u_lms_host.wr(IDX_CTRL, 8'h00, r);
		u_lms_host.wr(IDX_EXTC, 8'h00, r);
		u_lms_host.wr(IDX_PAGE, 8'h01, r);
		u_lms_host.wr(IDX_DOT0, {4'($random(seed)) | 4'h8, 4'h0}, r);
		a = 0;
		while (dot_on[0] !== 1'b1 && a < 40) begin
			@(posedge sys_clk);
			a++;
		end
		chk("dot_live", 1, dot_on[0], 0);
		// cycle rewrite, then delay rewrite, on the neighbour dot
		for (k = 0; k < 2; k++) begin
			u_lms_host.wr(IDX_DOT0 + 7'd1, 8'h54 + 8'(k), r);
			a = 0;
			b = 0;
			repeat (160) begin
				@(posedge sys_clk);
				a += (dot_on[0] !== 1'b1);
				b += (dot_on[1] === 1'b0);
			end
			chk("dot_steady", 0, a, 0);
			chk("dot_blink", 1, (b > 0 && b < 160), 0);
		end
		u_lms_host.wr(IDX_PAGE, 8'h00, r);
		// blinking neighbour dot must stay lit once scrolling runs
		u_lms_host.start_scroll(8'h00);
		b = 0;
		repeat (160) begin
			@(posedge sys_clk);
			b += (dot_on[1] !== 1'b1);
		end
		chk("scroll_lum", 0, b, 0);
		results;
	end
endmodule // led_matrix_scroll_update_tb
